//--- irq_status_pkg.sv
// Purpose: Constants and types for the UART interrupt status block
// Assumes: AHB-Lite word registers, 32-bit data
// Notes: Offsets are byte addresses
package irq_status_pkg;
  localparam logic [11:0] raw_status_off = 12'h03c;
  localparam logic [11:0] masked_status_off = 12'h040;
  localparam logic [11:0] irq_mask_off = 12'h038;
  localparam logic [11:0] irq_clear_off = 12'h044;
  localparam logic [11:0] fifo_level_select_off = 12'h034;
  localparam logic [11:0] line_control_off = 12'h030;
  localparam int bit_rx_dma = 16;
  localparam int bit_tx_dma = 17;
  localparam int bit_overrun = 10;
  localparam int bit_break = 9;
  localparam int bit_parity = 8;
  localparam int bit_framing = 7;
  localparam int bit_rx_timeout = 6;
  localparam int bit_tx = 5;
  localparam int bit_rx = 4;
  localparam int bit_cts = 1;
  localparam int bit_eot_select = 0;
  localparam logic [31:0] status_impl_mask = 32'h0003_07f2;
  localparam logic [31:0] status_reset = 32'h0000_0000;
  localparam logic [31:0] mask_reset = 32'h0000_0000;
  localparam logic [5:0] level_select_reset = 6'h12;
  localparam int fifo_ptr_w = 5;

  typedef enum logic [1:0] {
    trans_idle,
    trans_busy,
    trans_nonseq,
    trans_seq
  } htrans_t;

  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic rx_timeout;
    logic overrun;
    logic break_err;
    logic clear_to_send;
    logic tx_dma_done;
    logic rx_dma_done;
    logic tx_serializer_idle;
    logic tx_fifo_write;
    logic rx_fifo_read;
    logic fifo_enable;
    logic [fifo_ptr_w-1:0] tx_level;
    logic [fifo_ptr_w-1:0] rx_level;
  } uart_events_t;
endpackage : irq_status_pkg

//--- tb_uart_irq_status.sv
// Purpose: Register-level tests of the interrupt status block
// Assumes: Triggers at 8 of 16 by default, 12 after the level select write
// Notes: One transfer at a time; back-to-back overlap is left untested
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb_uart_irq_status
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, fen_cfg;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, got;
  logic [7:0] pulse = 0;
  logic idle = 0, wr = 0, rdp = 0, fen = 1;
  logic [4:0] txl = 0, rxl = 0;
  logic [5:0] lvl;
  uart_events_t events;
  int n_errors = 0, total_checks = 0;
  int bitpos[8] = '{8, 7, 6, 10, 9, 1, 17, 16};
  uart_core_model i_uart_core_model (.pulse(pulse), .idle(idle), .wr(wr), .rd(rdp), .fen(fen),
    .txl(txl), .rxl(rxl), .events(events));
  uart_irq_status i_uart_irq_status (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(events),
    .fifo_enable_cfg(fen_cfg), .level_select_cfg(lvl), .irq(irq));
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    got = hrdata;
  endtask : xfer
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(got, e)
  endtask : rchk
  task automatic hit(input logic [7:0] p);
    @(posedge hclk) pulse <= p;
    @(posedge hclk) pulse <= 8'h0;
  endtask : hit
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  initial begin
    #100us;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    rchk(masked_status_off, 32'h0);
    `CHK(irq, 1'b0)
    rchk(irq_mask_off, mask_reset);
    rchk(fifo_level_select_off, 32'(level_select_reset));
    hit(8'h80);
    rchk(raw_status_off, 32'h100);
    rchk(masked_status_off, 32'h0);
    `CHK(irq, 1'b0)
    xfer(1'b1, irq_clear_off, 32'h100);
    xfer(1'b1, irq_mask_off, status_impl_mask);
    rchk(irq_mask_off, status_impl_mask);
    foreach (bitpos[i]) begin
      hit(8'h80 >> i);
      rchk(raw_status_off, 32'h1 << bitpos[i]);
      xfer(1'b1, raw_status_off, 32'h0);
      xfer(1'b1, masked_status_off, 32'h0);
      rchk(masked_status_off, 32'h1 << bitpos[i]);
      `CHK(irq, 1'b1)
      xfer(1'b1, irq_clear_off, 32'h1 << bitpos[i]);
      rchk(raw_status_off, 32'h0);
      `CHK(irq, 1'b0)
    end
    @(posedge hclk) txl <= 5'd9;
    @(posedge hclk) txl <= 5'd8;
    rchk(raw_status_off, 32'h20);
    @(posedge hclk) begin txl <= 5'd9; wr <= 1; end
    @(posedge hclk) wr <= 0;
    rchk(raw_status_off, 32'h0);
    @(posedge hclk) rxl <= 5'd7;
    @(posedge hclk) rxl <= 5'd8;
    rchk(raw_status_off, 32'h10);
    @(posedge hclk) begin rxl <= 5'd7; rdp <= 1; end
    @(posedge hclk) rdp <= 0;
    rchk(raw_status_off, 32'h0);
    xfer(1'b1, fifo_level_select_off, 32'h1b);
    rchk(fifo_level_select_off, 32'h1b);
    `CHK(lvl, 6'h1b)
    @(posedge hclk) rxl <= 5'd11;
    @(posedge hclk) rxl <= 5'd12;
    rchk(raw_status_off, 32'h10);
    xfer(1'b1, irq_clear_off, 32'h10);
    rchk(raw_status_off, 32'h0);
    fen <= 0;
    xfer(1'b1, line_control_off, 32'h1);
    `CHK(fen_cfg, 1'b0)
    @(posedge hclk) idle <= 1;
    rchk(raw_status_off, 32'h20);
    @(posedge hclk) wr <= 1;
    @(posedge hclk) wr <= 0;
    rchk(raw_status_off, 32'h0);
    rchk(12'h100, 32'h0);
    test_done();
  end
endmodule : tb_uart_irq_status

//--- uart_core_model.sv
// Purpose: Stand-in for the UART core that raises status events
// Assumes: Bench drives every control right after hclk rising edges
// Notes: Pure packing, so core timing is whatever the bench commands
module uart_core_model
  import irq_status_pkg::*;
(
  // Bench controls
  input wire logic [7:0] pulse,
  input wire logic idle,
  input wire logic wr,
  input wire logic rd,
  input wire logic fen,
  input wire logic [fifo_ptr_w-1:0] txl,
  input wire logic [fifo_ptr_w-1:0] rxl,
  // Toward the block
  output uart_events_t events
);
  timeunit 1ns;
  timeprecision 100ps;
  assign events = {pulse, idle, wr, rd, fen, txl, rxl};
endmodule : uart_core_model

//--- uart_irq_status.sv
// Purpose: Raw and masked interrupt status of a UART with AHB-Lite registers
// Assumes: Event inputs come from logic on hclk, one-cycle pulses
// Notes: FIFO levels are fill counts 0..depth
// Contract
// [RULE_01] Parity error sets raw bit 8; one written to its clear bit clears it.
// [RULE_02] Framing error sets raw bit 7; cleared by writing its clear bit.
// [RULE_03] Receive time-out sets raw bit 6; cleared by writing its clear bit.
// [RULE_04] Without end-of-transmission select, tx level crossing trigger sets raw bit 5.
// [RULE_05] With end-of-transmission select, tx raw sets when serializer goes idle.
// [RULE_06] Tx raw clears by clear bit, fill above trigger, or unbuffered write.
// [RULE_07] Rx level crossing programmed trigger sets raw bit 4.
// [RULE_08] Rx raw clears by clear bit, fill below trigger, or unbuffered read.
// [RULE_09] Clear-to-send event sets raw bit 1; cleared by writing its clear bit.
// [RULE_10] Masked status at 40h reads masked value; writes ignored.
// [RULE_11] Masked status reads zero after reset.
// [RULE_12] Masked bit is one only for a pending unmasked event.
// [RULE_13] Masked bit 17 shows unmasked tx DMA done; cleared by its clear bit.
// [RULE_14] Masked bit 16 shows unmasked rx DMA done; cleared by its clear bit.
// [RULE_15] Masked bit 10 shows unmasked overrun; cleared by its clear bit.
// [RULE_16] Masked bit 9 shows unmasked break; cleared by its clear bit.
// [RULE_17] Raw status reads unmasked state of each source; writes ignored.
// [RULE_18] Mask bit one forwards its raw status; zero suppresses it.
// [RULE_19] Raw bits 10 and 9 record overrun and break, each own clear bit.
// [RULE_20] Reserved status bits read zero in both status registers.
// [RULE_21] Interrupt request is the OR of all masked status bits.
module uart_irq_status
  import irq_status_pkg::*;
#(
  parameter int fifo_depth = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // UART core events
  input wire uart_events_t events,
  // Configuration seen by the core
  output logic fifo_enable_cfg,
  output logic [5:0] level_select_cfg,
  // Interrupt controller
  output logic irq
);

  // Level counters are fifo_ptr_w bits wide and must hold a full FIFO
  if (fifo_depth < 2 || fifo_depth > (1 << fifo_ptr_w) - 1) begin : g_depth_check
    $error("fifo_depth out of range");
  end

  typedef struct packed {
    logic [31:0] raw;
    logic [31:0] mask;
    logic [5:0] level_sel;
    logic [7:0] line_ctl;
    logic [fifo_ptr_w-1:0] tx_level_d;
    logic [fifo_ptr_w-1:0] rx_level_d;
    logic idle_d;
    logic wr_pend;
    logic [11:0] addr_d;
    logic [31:0] rdata;
    logic irq;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Trigger level in entries from a 3-bit select: 1/8,1/4,1/2,3/4,7/8
  function automatic logic [fifo_ptr_w-1:0] trig_level(input logic [2:0] sel);
    logic [7:0] eighths;
    logic [15:0] prod;
    eighths = 8'h04;
    case (sel)
      3'h0: eighths = 8'h01;
      3'h1: eighths = 8'h02;
      3'h2: eighths = 8'h04;
      3'h3: eighths = 8'h06;
      3'h4: eighths = 8'h07;
      default: eighths = 8'h04;
    endcase
    prod = 16'(eighths) * 16'(fifo_depth);
    return fifo_ptr_w'(prod >> 3);
  endfunction : trig_level

  // One status bit: an event in the same cycle as its clear wins
  function automatic logic sticky(input logic old, input logic set, input logic clr);
    return set || (old && !clr);
  endfunction : sticky

  // Write data phase aimed at one register offset
  function automatic logic wr_hit(input state_t s, input logic [11:0] a);
    return s.wr_pend && s.addr_d == a;
  endfunction : wr_hit

  // Status words come in as views, so reserved bits are zero by construction
  function automatic logic [31:0] read_word(input state_t s, input logic [31:0] raw_v,
    input logic [31:0] masked_v, input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      raw_status_off: w = raw_v; // see [RULE_17] see [RULE_20]
      masked_status_off: w = masked_v; // see [RULE_10] see [RULE_12]
      irq_mask_off: w = s.mask;
      fifo_level_select_off: w = {26'h0, s.level_sel};
      line_control_off: w = {24'h0, s.line_ctl};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // Bus decode
  logic take;
  logic take_read;
  logic take_write;
  logic [11:0] addr_word;
  logic wr_mask;
  logic wr_level_sel;
  logic wr_line_ctl;
  logic wr_clear;
  logic [31:0] wdata_impl;
  // Trigger levels and transmit mode
  logic [fifo_ptr_w-1:0] tx_trig;
  logic [fifo_ptr_w-1:0] rx_trig;
  logic eot_sel;
  logic tx_cross;
  logic tx_done;
  logic rx_cross;
  logic tx_write_clr;
  logic rx_read_clr;
  // Set and clear of each source
  logic set_parity;
  logic clr_parity;
  logic set_framing;
  logic clr_framing;
  logic set_rx_timeout;
  logic clr_rx_timeout;
  logic set_cts;
  logic clr_cts;
  logic set_overrun;
  logic clr_overrun;
  logic set_break;
  logic clr_break;
  logic set_tx_dma;
  logic clr_tx_dma;
  logic set_rx_dma;
  logic clr_rx_dma;
  logic set_tx;
  logic clr_tx;
  logic set_rx;
  logic clr_rx;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  // Register views
  logic parity_err_raw;
  logic framing_err_raw;
  logic rx_timeout_raw;
  logic tx_raw;
  logic rx_raw;
  logic clear_to_send_raw;
  logic overrun_raw;
  logic break_raw;
  logic tx_dma_done_raw;
  logic rx_dma_done_raw;
  logic data_set_ready_raw_reserved;
  logic carrier_detect_raw_reserved;
  logic ring_indicate_raw_reserved;
  logic tx_dma_done_masked;
  logic rx_dma_done_masked;
  logic overrun_masked;
  logic break_masked;
  logic [31:0] raw_view;
  logic [31:0] masked_view;

  // Only whole words are served, so hsize is not decoded
  assign take = hsel && hready && (htrans == trans_nonseq || htrans == trans_seq);
  assign take_read = take && !hwrite;
  assign take_write = take && hwrite;
  assign addr_word = {haddr[11:2], 2'b00};
  assign wr_mask = wr_hit(state_reg, irq_mask_off);
  assign wr_level_sel = wr_hit(state_reg, fifo_level_select_off);
  assign wr_line_ctl = wr_hit(state_reg, line_control_off);
  assign wr_clear = wr_hit(state_reg, irq_clear_off);
  // Clear bits share the status layout; unimplemented positions are dropped
  assign wdata_impl = hwdata & status_impl_mask;

  assign tx_trig = trig_level(state_reg.level_sel[2:0]);
  assign rx_trig = trig_level(state_reg.level_sel[5:3]);
  assign eot_sel = state_reg.line_ctl[bit_eot_select];

  // Error, modem and DMA events set their bit; a one in the clear word clears it
  assign set_parity = events.parity_err; // see [RULE_01]
  assign clr_parity = wr_clear && wdata_impl[bit_parity]; // see [RULE_01]
  assign set_framing = events.framing_err; // see [RULE_02]
  assign clr_framing = wr_clear && wdata_impl[bit_framing]; // see [RULE_02]
  assign set_rx_timeout = events.rx_timeout; // see [RULE_03]
  assign clr_rx_timeout = wr_clear && wdata_impl[bit_rx_timeout]; // see [RULE_03]
  assign set_cts = events.clear_to_send; // see [RULE_09]
  assign clr_cts = wr_clear && wdata_impl[bit_cts]; // see [RULE_09]
  assign set_overrun = events.overrun; // see [RULE_19]
  assign clr_overrun = wr_clear && wdata_impl[bit_overrun]; // see [RULE_15] see [RULE_19]
  assign set_break = events.break_err; // see [RULE_19]
  assign clr_break = wr_clear && wdata_impl[bit_break]; // see [RULE_16] see [RULE_19]
  assign set_tx_dma = events.tx_dma_done; // see [RULE_13]
  assign clr_tx_dma = wr_clear && wdata_impl[bit_tx_dma]; // see [RULE_13]
  assign set_rx_dma = events.rx_dma_done; // see [RULE_14]
  assign clr_rx_dma = wr_clear && wdata_impl[bit_rx_dma]; // see [RULE_14]

  // Transmit: a level crossing, or with end-of-transmission select the idle edge
  assign tx_cross = state_reg.tx_level_d > tx_trig && events.tx_level <= tx_trig; // see [RULE_04]
  // Rising idle marks the last stop bit leaving the serializer
  assign tx_done = events.tx_serializer_idle && !state_reg.idle_d; // see [RULE_05]
  assign set_tx = eot_sel ? tx_done : tx_cross;
  // Level is the fill after the write, so above trigger means the write crossed it
  assign tx_write_clr = events.tx_fifo_write &&
    (!events.fifo_enable || events.tx_level > tx_trig);
  assign clr_tx = tx_write_clr || (wr_clear && wdata_impl[bit_tx]); // see [RULE_06]

  // Receive: crossing upward sets, a read that drops below the trigger clears
  assign rx_cross = state_reg.rx_level_d < rx_trig && events.rx_level >= rx_trig; // see [RULE_07]
  assign set_rx = rx_cross;
  assign rx_read_clr = events.rx_fifo_read &&
    (!events.fifo_enable || events.rx_level < rx_trig);
  assign clr_rx = rx_read_clr || (wr_clear && wdata_impl[bit_rx]); // see [RULE_08]

  // Views as software reads them; reserved positions are constant zero
  assign parity_err_raw = state_reg.raw[bit_parity];
  assign framing_err_raw = state_reg.raw[bit_framing];
  assign rx_timeout_raw = state_reg.raw[bit_rx_timeout];
  assign tx_raw = state_reg.raw[bit_tx];
  assign rx_raw = state_reg.raw[bit_rx];
  assign clear_to_send_raw = state_reg.raw[bit_cts];
  assign overrun_raw = state_reg.raw[bit_overrun];
  assign break_raw = state_reg.raw[bit_break];
  assign tx_dma_done_raw = state_reg.raw[bit_tx_dma];
  assign rx_dma_done_raw = state_reg.raw[bit_rx_dma];
  assign data_set_ready_raw_reserved = 1'b0; // see [RULE_20]
  assign carrier_detect_raw_reserved = 1'b0; // see [RULE_20]
  assign ring_indicate_raw_reserved = 1'b0; // see [RULE_20]
  assign raw_view = {14'h0000, tx_dma_done_raw, rx_dma_done_raw, 5'h00, overrun_raw,
    break_raw, parity_err_raw, framing_err_raw, rx_timeout_raw, tx_raw, rx_raw,
    data_set_ready_raw_reserved, carrier_detect_raw_reserved, clear_to_send_raw,
    ring_indicate_raw_reserved}; // see [RULE_17]
  // Masked view: each bit needs both the pending event and its mask bit
  assign tx_dma_done_masked = tx_dma_done_raw && state_reg.mask[bit_tx_dma]; // see [RULE_13]
  assign rx_dma_done_masked = rx_dma_done_raw && state_reg.mask[bit_rx_dma]; // see [RULE_14]
  assign overrun_masked = overrun_raw && state_reg.mask[bit_overrun]; // see [RULE_15]
  assign break_masked = break_raw && state_reg.mask[bit_break]; // see [RULE_16]
  assign masked_view = {14'h0000, tx_dma_done_masked, rx_dma_done_masked, 5'h00, overrun_masked,
    break_masked, raw_view[8:0] & state_reg.mask[8:0]}; // see [RULE_12] see [RULE_18]

  always_comb begin
    state_next = state_reg;
    set_vec = 32'h0000_0000;
    clr_vec = 32'h0000_0000;
    // Gather per-source sets and clears into status-shaped words
    set_vec[bit_parity] = set_parity;
    set_vec[bit_framing] = set_framing;
    set_vec[bit_rx_timeout] = set_rx_timeout;
    set_vec[bit_cts] = set_cts;
    set_vec[bit_overrun] = set_overrun;
    set_vec[bit_break] = set_break;
    set_vec[bit_tx_dma] = set_tx_dma;
    set_vec[bit_rx_dma] = set_rx_dma;
    set_vec[bit_tx] = set_tx;
    set_vec[bit_rx] = set_rx;
    clr_vec[bit_parity] = clr_parity;
    clr_vec[bit_framing] = clr_framing;
    clr_vec[bit_rx_timeout] = clr_rx_timeout;
    clr_vec[bit_cts] = clr_cts;
    clr_vec[bit_overrun] = clr_overrun;
    clr_vec[bit_break] = clr_break;
    clr_vec[bit_tx_dma] = clr_tx_dma;
    clr_vec[bit_rx_dma] = clr_rx_dma;
    clr_vec[bit_tx] = clr_tx;
    clr_vec[bit_rx] = clr_rx;
    // A new event wins over a clear in the same cycle; reserved bits never store
    for (int i = 0; i < 32; i++) begin
      state_next.raw[i] = sticky(state_reg.raw[i], set_vec[i], clr_vec[i]) && status_impl_mask[i];
    end
    // Previous levels and idle feed the crossing and edge detectors
    state_next.tx_level_d = events.tx_level;
    state_next.rx_level_d = events.rx_level;
    state_next.idle_d = events.tx_serializer_idle;
    // Both status registers are read only, so writes to them decode to nothing
    // see [RULE_10] see [RULE_17]
    if (wr_mask) begin
      state_next.mask = wdata_impl; // see [RULE_18]
    end
    if (wr_level_sel) begin
      state_next.level_sel = hwdata[5:0];
    end
    if (wr_line_ctl) begin
      state_next.line_ctl = hwdata[7:0];
    end
    // Address phase is remembered for the write data phase that follows
    state_next.wr_pend = take_write;
    if (take) begin
      state_next.addr_d = addr_word;
    end
    // Read data registered during address phase: one cycle, no wait states
    if (take_read) begin
      state_next.rdata = read_word(state_reg, raw_view, masked_view, addr_word); // see [RULE_10]
    end else begin
      state_next.rdata = 32'h0000_0000;
    end
    // Registered from the next state so the line to the controller is glitch free, in the same cycle as raw
    state_next.irq = |(state_next.raw & state_next.mask); // see [RULE_18] see [RULE_21]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.raw <= status_reset; // see [RULE_11]
      state_reg.mask <= mask_reset;
      state_reg.level_sel <= level_select_reset;
      state_reg.line_ctl <= 8'h00;
      state_reg.tx_level_d <= '0;
      state_reg.rx_level_d <= '0;
      state_reg.idle_d <= 1'b1;
      state_reg.wr_pend <= 1'b0;
      state_reg.addr_d <= 12'h000;
      state_reg.rdata <= 32'h0000_0000;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_reg.rdata;
  assign irq = state_reg.irq;
  assign fifo_enable_cfg = state_reg.line_ctl[4];
  assign level_select_cfg = state_reg.level_sel;

endmodule : uart_irq_status

//--- uart_irq_status_properties.sv
// Purpose: Port-level properties of the interrupt status block
// Assumes: One AHB-Lite slave, hready tied to hreadyout
// Notes: Status bit values need event and mask history, so reads are judged by the bench
module uart_irq_status_checker
  import irq_status_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Core side
  input wire uart_events_t events,
  input wire logic [5:0] level_select_cfg,
  input wire logic irq
);
  logic take;
  logic wr_q;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_always: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_raw_reserved: assert property (take && !hwrite && haddr == raw_status_off
    |=> (hrdata & ~status_impl_mask) == 32'h0) else $error("raw reserved bit set");
  a_masked_reserved: assert property (take && !hwrite && haddr == masked_status_off
    |=> (hrdata & ~status_impl_mask) == 32'h0) else $error("masked reserved bit set");
  a_rdata_idle: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
    else $error("hrdata outside data phase");
  a_irq_after_reset: assert property ($rose(hresetn) |-> !irq)
    else $error("irq after reset");
  a_irq_fall_cause: assert property ($fell(irq)
    |-> $past(wr_q || events.tx_fifo_write || events.rx_fifo_read)) else $error("irq fell");
  a_cfg_by_write: assert property ($changed(level_select_cfg) |-> $past(wr_q))
    else $error("level select moved");
  c_irq_raised: cover property ($rose(irq));
  c_irq_cleared: cover property ($fell(irq));
  c_masked_read: cover property (take && haddr == masked_status_off ##1 hrdata != 32'h0);
endmodule : uart_irq_status_checker

bind uart_irq_status uart_irq_status_checker i_uart_irq_status_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(events),
  .level_select_cfg(level_select_cfg), .irq(irq));
